// ### aotf_pkg.sv
// Shared constants and types for the converter output test and format control block.
// Assumes a byte-wide register port decoded from the serial control port.
package aotf_pkg;

    // Register addresses.
    localparam logic [7:0] ADDR_PATTERN_SELECT = 8'h0d;
    localparam logic [7:0] ADDR_OUTPUT_FORMAT  = 8'h14;
    localparam logic [7:0] ADDR_DRIVER_TERM    = 8'h15;
    localparam logic [7:0] ADDR_CLOCK_PHASE    = 8'h16;
    localparam logic [7:0] ADDR_CUSTOM_A_LOW   = 8'h19;
    localparam logic [7:0] ADDR_CUSTOM_A_HIGH  = 8'h1a;
    localparam logic [7:0] ADDR_CUSTOM_B_LOW   = 8'h1b;
    localparam logic [7:0] ADDR_CUSTOM_B_HIGH  = 8'h1c;

    // Reset values.
    localparam logic [7:0] RST_PATTERN_SELECT = 8'h00;
    localparam logic [7:0] RST_OUTPUT_FORMAT  = 8'h00;
    localparam logic [7:0] RST_DRIVER_TERM    = 8'h00;
    localparam logic [7:0] RST_CLOCK_PHASE    = 8'h03;
    localparam logic [7:0] RST_CUSTOM_BYTE    = 8'h00;

    // Field positions.
    localparam int MODE_LSB       = 0;
    localparam int SHORT_RST_BIT  = 4;
    localparam int LONG_RST_BIT   = 5;
    localparam int FMT_LSB        = 0;
    localparam int INVERT_BIT     = 2;
    localparam int PHASE_LSB      = 0;

    // Writable bits of each register; the rest read as zero.
    localparam logic [7:0] MASK_PATTERN_SELECT = 8'hff;
    localparam logic [7:0] MASK_OUTPUT_FORMAT  = 8'h47;
    localparam logic [7:0] MASK_DRIVER_TERM    = 8'h30;
    localparam logic [7:0] MASK_CLOCK_PHASE    = 8'h0f;

    localparam int SAMPLE_W = 10;

    // Fixed pattern words, offset binary where format applies.
    localparam logic [9:0] WORD_MIDSCALE  = 10'h200;
    localparam logic [9:0] WORD_POS_FS    = 10'h3ff;
    localparam logic [9:0] WORD_NEG_FS    = 10'h000;
    localparam logic [9:0] WORD_CHECKER_A = 10'h2aa;
    localparam logic [9:0] WORD_CHECKER_B = 10'h155;
    localparam logic [9:0] WORD_ONES      = 10'h3ff;
    localparam logic [9:0] WORD_ZEROS     = 10'h000;
    localparam logic [9:0] WORD_BIT_TOG   = 10'h2aa;
    localparam logic [9:0] WORD_SYNC      = 10'h3e0;
    localparam logic [9:0] WORD_ONE_HIGH  = 10'h200;
    localparam logic [9:0] WORD_MIXED     = 10'h0a3;

    // Generator seeds; all ones keeps the sequences out of the lock-up state.
    localparam logic [22:0] SEED_LONG  = 23'h7fffff;
    localparam logic [8:0]  SEED_SHORT = 9'h1ff;

    typedef enum logic [3:0] {
        MODE_OFF       = 4'b0000,
        MODE_MIDSCALE  = 4'b0001,
        MODE_POS_FS    = 4'b0010,
        MODE_NEG_FS    = 4'b0011,
        MODE_CHECKER   = 4'b0100,
        MODE_PN_LONG   = 4'b0101,
        MODE_PN_SHORT  = 4'b0110,
        MODE_WORD_TOG  = 4'b0111,
        MODE_CUSTOM    = 4'b1000,
        MODE_BIT_TOG   = 4'b1001,
        MODE_SYNC      = 4'b1010,
        MODE_ONE_HIGH  = 4'b1011,
        MODE_MIXED     = 4'b1100
    } aotf_mode_t;

    localparam logic [1:0] FMT_OFFSET_BIN = 2'b00;
    localparam logic [1:0] FMT_TWOS_COMP  = 2'b01;

    // Settings that take effect together at a frame boundary.
    typedef struct packed {
        logic [3:0] mode;
        logic [1:0] fmt;
        logic       invert;
        logic [3:0] phase;
    } aotf_cfg_t;

endpackage : aotf_pkg

// ### aotf_ctrl.sv
// Output test pattern, format and clock phase control for one converter output lane.
// Assumes register accesses arrive already decoded from the serial control port, and
// that frame_strobe pulses once per output word, synchronous to clk_sys.
//
// What this block does
// R1: A test mode code of 1 to 12 replaces converted samples with the chosen pattern.
// R2: Codes 0 to 4 give normal, midscale, plus full scale, minus full scale, checkerboard.
// R3: Code 5 gives the order 23 sequence, code 6 the order 9 sequence.
// R4: Code 7 toggles all-ones/zeros words, 8 user words, 9 alternating bits.
// R5: Code 10 sync word, 11 single high bit, 12 mixed pattern in set format.
// R6: Long sequence reset bit set holds that generator in reset; cleared lets it run.
// R7: Short sequence reset bit set holds that generator in reset; cleared lets it run.
// R8: Format field 00 gives offset binary, 01 gives twos complement.
// R9: Invert bit set inverts every output data bit.
// R10: Four-bit phase field steps output clock by 60 degrees, resetting to 180.
// R11: Software writes only phase codes 0 through 10.
// R12: Phase only picks the divider phase; data latching timing stays the same.
// R13: User words come from two 16-bit registers, byte pairs, reset to zero.
// R14: Mode, format and phase changes apply only at the next frame boundary.
`timescale 1ns/1ns
`default_nettype none

module aotf_ctrl (
    // Clock and reset.
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    // Register port from the serial control interface.
    input  wire logic                 reg_wr_en,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wr_data,
    output logic      [7:0]           reg_rd_data,
    // Converted samples, one per frame.
    input  wire logic                 frame_strobe,
    input  wire logic [9:0]           sample_in,
    // Output words, clock phase select and driver termination.
    output logic      [9:0]           data_out,
    output logic                      data_valid,
    output logic      [3:0]           out_clk_phase,
    output logic      [1:0]           driver_term
);

    // Reset release through two flops.
    logic rst_meta;
    logic rst_sync_n;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    function automatic logic [9:0] apply_format(input logic [9:0] w, input logic [1:0] fmt);
        // Twos complement of an offset binary word is the word with its sign bit flipped.
        apply_format = (fmt == aotf_pkg::FMT_TWOS_COMP) ? {~w[9], w[8:0]} : w; // R8
    endfunction : apply_format

    // Register group.
    logic [7:0] pattern_select_and_gen_reset;
    logic [7:0] output_format_config;
    logic [7:0] driver_termination_config;
    logic [7:0] clock_phase_select;
    logic [7:0] custom_word_a_low;
    logic [7:0] custom_word_a_high;
    logic [7:0] custom_word_b_low;
    logic [7:0] custom_word_b_high;
    logic [7:0] next_pattern_select_and_gen_reset;
    logic [7:0] next_output_format_config;
    logic [7:0] next_driver_termination_config;
    logic [7:0] next_clock_phase_select;
    logic [7:0] next_custom_word_a_low;
    logic [7:0] next_custom_word_a_high;
    logic [7:0] next_custom_word_b_low;
    logic [7:0] next_custom_word_b_high;
    logic [7:0] next_reg_rd_data;

    always_comb begin
        next_pattern_select_and_gen_reset = pattern_select_and_gen_reset;
        next_output_format_config         = output_format_config;
        next_driver_termination_config    = driver_termination_config;
        next_clock_phase_select           = clock_phase_select;
        next_custom_word_a_low            = custom_word_a_low;
        next_custom_word_a_high           = custom_word_a_high;
        next_custom_word_b_low            = custom_word_b_low;
        next_custom_word_b_high           = custom_word_b_high;
        if (reg_wr_en) begin
            unique case (reg_addr)
                aotf_pkg::ADDR_PATTERN_SELECT:
                    next_pattern_select_and_gen_reset = reg_wr_data & aotf_pkg::MASK_PATTERN_SELECT;
                aotf_pkg::ADDR_OUTPUT_FORMAT:
                    next_output_format_config = reg_wr_data & aotf_pkg::MASK_OUTPUT_FORMAT;
                aotf_pkg::ADDR_DRIVER_TERM:
                    next_driver_termination_config = reg_wr_data & aotf_pkg::MASK_DRIVER_TERM;
                // Codes above 1010 are the writer's fault and are stored as written.
                aotf_pkg::ADDR_CLOCK_PHASE:
                    next_clock_phase_select = reg_wr_data & aotf_pkg::MASK_CLOCK_PHASE; // R11
                aotf_pkg::ADDR_CUSTOM_A_LOW:  next_custom_word_a_low  = reg_wr_data; // R13
                aotf_pkg::ADDR_CUSTOM_A_HIGH: next_custom_word_a_high = reg_wr_data; // R13
                aotf_pkg::ADDR_CUSTOM_B_LOW:  next_custom_word_b_low  = reg_wr_data; // R13
                aotf_pkg::ADDR_CUSTOM_B_HIGH: next_custom_word_b_high = reg_wr_data; // R13
                default: ;
            endcase
        end
        unique case (reg_addr)
            aotf_pkg::ADDR_PATTERN_SELECT: next_reg_rd_data = pattern_select_and_gen_reset;
            aotf_pkg::ADDR_OUTPUT_FORMAT:  next_reg_rd_data = output_format_config;
            aotf_pkg::ADDR_DRIVER_TERM:    next_reg_rd_data = driver_termination_config;
            aotf_pkg::ADDR_CLOCK_PHASE:    next_reg_rd_data = clock_phase_select;
            aotf_pkg::ADDR_CUSTOM_A_LOW:   next_reg_rd_data = custom_word_a_low;
            aotf_pkg::ADDR_CUSTOM_A_HIGH:  next_reg_rd_data = custom_word_a_high;
            aotf_pkg::ADDR_CUSTOM_B_LOW:   next_reg_rd_data = custom_word_b_low;
            aotf_pkg::ADDR_CUSTOM_B_HIGH:  next_reg_rd_data = custom_word_b_high;
            default:                       next_reg_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pattern_select_and_gen_reset <= aotf_pkg::RST_PATTERN_SELECT;
            output_format_config         <= aotf_pkg::RST_OUTPUT_FORMAT;
            driver_termination_config    <= aotf_pkg::RST_DRIVER_TERM;
            clock_phase_select           <= aotf_pkg::RST_CLOCK_PHASE; // R10
            custom_word_a_low            <= aotf_pkg::RST_CUSTOM_BYTE; // R13
            custom_word_a_high           <= aotf_pkg::RST_CUSTOM_BYTE;
            custom_word_b_low            <= aotf_pkg::RST_CUSTOM_BYTE;
            custom_word_b_high           <= aotf_pkg::RST_CUSTOM_BYTE;
            reg_rd_data                  <= 8'h00;
        end else begin
            pattern_select_and_gen_reset <= next_pattern_select_and_gen_reset;
            output_format_config         <= next_output_format_config;
            driver_termination_config    <= next_driver_termination_config;
            clock_phase_select           <= next_clock_phase_select;
            custom_word_a_low            <= next_custom_word_a_low;
            custom_word_a_high           <= next_custom_word_a_high;
            custom_word_b_low            <= next_custom_word_b_low;
            custom_word_b_high           <= next_custom_word_b_high;
            reg_rd_data                  <= next_reg_rd_data;
        end
    end

    // Output group: settings, generators and the output word.
    aotf_pkg::aotf_cfg_t cfg_live;
    aotf_pkg::aotf_cfg_t cfg_act;
    aotf_pkg::aotf_cfg_t next_cfg_act;
    logic [22:0]         pn_long;
    logic [22:0]         next_pn_long;
    logic [8:0]          pn_short;
    logic [8:0]          next_pn_short;
    logic                alt_sel;
    logic                next_alt_sel;
    logic [9:0]          pattern_word;
    logic [9:0]          next_data_out;
    logic                next_data_valid;
    logic [1:0]          next_driver_term;
    logic                hold_long;
    logic                hold_short;

    always_comb begin
        cfg_live.mode   = pattern_select_and_gen_reset[aotf_pkg::MODE_LSB +: 4];
        cfg_live.fmt    = output_format_config[aotf_pkg::FMT_LSB +: 2];
        cfg_live.invert = output_format_config[aotf_pkg::INVERT_BIT];
        cfg_live.phase  = clock_phase_select[aotf_pkg::PHASE_LSB +: 4];
        hold_long       = pattern_select_and_gen_reset[aotf_pkg::LONG_RST_BIT];
        hold_short      = pattern_select_and_gen_reset[aotf_pkg::SHORT_RST_BIT];

        // Settings are sampled only on a frame so a word is never split across two settings.
        next_cfg_act = frame_strobe ? cfg_live : cfg_act; // R14
        next_alt_sel = frame_strobe ? ~alt_sel : alt_sel;

        // Generators step once per frame, so each output word is a fresh sequence value.
        if (hold_long) begin
            next_pn_long = aotf_pkg::SEED_LONG; // R6
        end else if (frame_strobe) begin
            next_pn_long = {pn_long[21:0], pn_long[22] ^ pn_long[17]}; // R3
        end else begin
            next_pn_long = pn_long;
        end
        if (hold_short) begin
            next_pn_short = aotf_pkg::SEED_SHORT; // R7
        end else if (frame_strobe) begin
            next_pn_short = {pn_short[7:0], pn_short[8] ^ pn_short[4]}; // R3
        end else begin
            next_pn_short = pn_short;
        end

        unique case (cfg_live.mode)
            aotf_pkg::MODE_OFF:      pattern_word = apply_format(sample_in, cfg_live.fmt); // R2
            aotf_pkg::MODE_MIDSCALE: pattern_word = apply_format(aotf_pkg::WORD_MIDSCALE, cfg_live.fmt); // R2
            aotf_pkg::MODE_POS_FS:   pattern_word = apply_format(aotf_pkg::WORD_POS_FS, cfg_live.fmt); // R2
            aotf_pkg::MODE_NEG_FS:   pattern_word = apply_format(aotf_pkg::WORD_NEG_FS, cfg_live.fmt); // R2
            aotf_pkg::MODE_CHECKER:  pattern_word = alt_sel ? aotf_pkg::WORD_CHECKER_B
                                                            : aotf_pkg::WORD_CHECKER_A; // R2
            aotf_pkg::MODE_PN_LONG:  pattern_word = pn_long[9:0]; // R3
            aotf_pkg::MODE_PN_SHORT: pattern_word = {1'b0, pn_short}; // R3
            aotf_pkg::MODE_WORD_TOG: pattern_word = alt_sel ? aotf_pkg::WORD_ZEROS : aotf_pkg::WORD_ONES; // R4
            aotf_pkg::MODE_CUSTOM:   pattern_word = alt_sel ? {custom_word_b_high, custom_word_b_low[7:6]}
                                                            : {custom_word_a_high, custom_word_a_low[7:6]}; // R4
            aotf_pkg::MODE_BIT_TOG:  pattern_word = aotf_pkg::WORD_BIT_TOG; // R4
            aotf_pkg::MODE_SYNC:     pattern_word = aotf_pkg::WORD_SYNC; // R5
            aotf_pkg::MODE_ONE_HIGH: pattern_word = aotf_pkg::WORD_ONE_HIGH; // R5
            aotf_pkg::MODE_MIXED:    pattern_word = apply_format(aotf_pkg::WORD_MIXED, cfg_live.fmt); // R5
            // Codes 1101 to 1111 are undefined; normal data is the safe choice.
            default:                 pattern_word = apply_format(sample_in, cfg_live.fmt); // R1
        endcase

        if (frame_strobe) begin
            next_data_out = cfg_live.invert ? ~pattern_word : pattern_word; // R9
        end else begin
            next_data_out = data_out;
        end
        next_data_valid  = frame_strobe;
        next_driver_term = driver_termination_config[5:4];
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cfg_act     <= '{mode: 4'h0, fmt: 2'h0, invert: 1'b0, phase: aotf_pkg::RST_CLOCK_PHASE[3:0]};
            pn_long     <= aotf_pkg::SEED_LONG;
            pn_short    <= aotf_pkg::SEED_SHORT;
            alt_sel     <= 1'b0;
            data_out    <= 10'h000;
            data_valid  <= 1'b0;
            driver_term <= 2'h0;
        end else begin
            cfg_act     <= next_cfg_act;
            pn_long     <= next_pn_long;
            pn_short    <= next_pn_short;
            alt_sel     <= next_alt_sel;
            data_out    <= next_data_out;
            data_valid  <= next_data_valid;
            driver_term <= next_driver_term;
        end
    end

    // The phase output only steers the divider tap; data timing does not depend on it.
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            out_clk_phase <= aotf_pkg::RST_CLOCK_PHASE[3:0]; // R10
        end else begin
            out_clk_phase <= next_cfg_act.phase; // R12
        end
    end

endmodule : aotf_ctrl
`default_nettype wire

// ### aotf_ctrl_chk.sv
// Concurrent checks on the ports of the output test and format control block.
// Assumes it is bound to aotf_ctrl and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module aotf_ctrl_chk (
    // Clock and reset.
    input wire logic       clk_sys,
    input wire logic       reset_n,
    // Register port.
    input wire logic       reg_wr_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data,
    // Output stream.
    input wire logic       frame_strobe,
    input wire logic [9:0] sample_in,
    input wire logic [9:0] data_out,
    input wire logic       data_valid,
    input wire logic [3:0] out_clk_phase,
    input wire logic [1:0] driver_term
);
    // Shadows rebuilt from port writes; the counter skips the two-flop reset lag.
    logic [3:0] mode, next_mode, phase_set, next_phase_set;
    logic [2:0] fmt_bits, next_fmt_bits;
    logic [1:0] up_cnt, next_up_cnt;
    logic       up;
    logic [9:0] inv_m, msb_f;
    assign up = (up_cnt == 2'd3);
    assign inv_m = {10{fmt_bits[2]}};
    assign msb_f = {fmt_bits[0], 9'h000};
    always_comb begin
        next_mode = mode;
        next_fmt_bits = fmt_bits;
        next_phase_set = phase_set;
        next_up_cnt = up ? up_cnt : up_cnt + 2'd1;
        if (reg_wr_en && reg_addr == aotf_pkg::ADDR_PATTERN_SELECT) next_mode = reg_wr_data[3:0];
        if (reg_wr_en && reg_addr == aotf_pkg::ADDR_OUTPUT_FORMAT) next_fmt_bits = reg_wr_data[2:0];
        if (reg_wr_en && reg_addr == aotf_pkg::ADDR_CLOCK_PHASE) next_phase_set = reg_wr_data[3:0];
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode <= 4'h0;
            fmt_bits <= 3'h0;
            phase_set <= 4'h3;
            up_cnt <= 2'd0;
        end else begin
            mode <= next_mode;
            fmt_bits <= next_fmt_bits;
            phase_set <= next_phase_set;
            up_cnt <= next_up_cnt;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_valid_follows: assert property (up && frame_strobe |=> data_valid) else $error("no valid after frame");
    a_valid_cause: assert property (data_valid |-> $past(frame_strobe)) else $error("valid without frame");
    a_word_holds: assert property (!frame_strobe |=> $stable(data_out)) else $error("word moved mid frame");
    a_phase_holds: assert property (!frame_strobe |=> $stable(out_clk_phase)) else $error("phase moved");
    a_normal_word: assert property (up && frame_strobe && mode == 4'h0 && !fmt_bits[1]
        |=> data_out == $past(sample_in ^ msb_f ^ inv_m)) else $error("normal word wrong");
    a_midscale_word: assert property (up && frame_strobe && mode == 4'h1 && !fmt_bits[1]
        |=> data_out == $past(10'h200 ^ msb_f ^ inv_m)) else $error("midscale wrong");
    a_phase_applies: assert property (up && frame_strobe |=> out_clk_phase == $past(phase_set))
        else $error("phase not applied");
    a_phase_readback: assert property (up && reg_addr == 8'h16 |=> reg_rd_data == {4'h0, $past(phase_set)})
        else $error("phase readback wrong");
    a_reset_phase: assert property ($rose(reset_n) |-> out_clk_phase == 4'h3) else $error("phase reset");
    c_custom: cover property (frame_strobe && mode == 4'h8);
    c_invert: cover property (frame_strobe && fmt_bits[2]);
    c_phase_wr: cover property (reg_wr_en && reg_addr == 8'h16);
endmodule : aotf_ctrl_chk
bind aotf_ctrl aotf_ctrl_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .frame_strobe(frame_strobe),
    .sample_in(sample_in), .data_out(data_out), .data_valid(data_valid), .out_clk_phase(out_clk_phase),
    .driver_term(driver_term));
`default_nettype wire

// ### aotf_capture_rx.sv
// Capture receiver model standing at the far side of the output words.
// Assumes data_valid marks each new word for one clk_sys cycle.
`timescale 1ns/1ns
`default_nettype none
module aotf_capture_rx (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // Word stream from the block.
    input  wire logic       data_valid,
    input  wire logic [9:0] data_out,
    // Captured words towards the bench.
    output logic            got_valid,
    output logic      [9:0] got_word
);
    // Latching on the pulse only, so a word held between frames is never taken twice.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            got_valid <= 1'b0;
            got_word  <= 10'h000;
        end else begin
            got_valid <= data_valid;
            got_word  <= data_valid ? data_out : got_word;
        end
    end
endmodule : aotf_capture_rx
`default_nettype wire

// ### test_adc_output_test_format_ctrl.sv
// Self-checking bench for the output test and format control block.
// Assumes the checker is bound in and the capture model receives the words.
`timescale 1ns/1ns
`default_nettype none
module test_adc_output_test_format_ctrl;
    logic clk_sys = 1'b0, reset_n, reg_wr_en, frame_strobe, data_valid, got_valid, inv;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
    logic [9:0] sample_in, data_out, got_word, s;
    logic [3:0] out_clk_phase, prev;
    logic [1:0] driver_term, fmt;
    logic [15:0] ua, ub;
    logic [10:0] expq[$], e;
    logic [9:0] alt_a[3], alt_b[3];
    logic [3:0] alt_m[3] = '{4'h4, 4'h7, 4'h8};
    logic [23:0] wtab[4] = '{24'h0dffff, 24'h14ff47, 24'h15ff30, 24'h16fa0a};
    logic [15:0] rtab[9] = '{16'h0d00, 16'h1400, 16'h1500, 16'h1603, 16'h1900, 16'h1a00, 16'h1b00,
                             16'h1c00, 16'h2000};
    logic [14:0] ftab[7] = '{{4'h1, 1'b1, 10'h200}, {4'h2, 1'b1, 10'h3ff}, {4'h3, 1'b1, 10'h000},
        {4'h9, 1'b0, 10'h2aa}, {4'ha, 1'b0, 10'h3e0}, {4'hb, 1'b0, 10'h200}, {4'hc, 1'b1, 10'h0a3}};
    int err_count = 0, checks = 0, nfrm = 0;
    always #25 clk_sys = ~clk_sys;
    aotf_ctrl DUT (.clk_sys(clk_sys), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .frame_strobe(frame_strobe),
        .sample_in(sample_in), .data_out(data_out), .data_valid(data_valid), .out_clk_phase(out_clk_phase),
        .driver_term(driver_term));
    aotf_capture_rx u_rx (.clk_sys(clk_sys), .reset_n(reset_n), .data_valid(data_valid), .data_out(data_out),
        .got_valid(got_valid), .got_word(got_word));
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    task automatic cmp(input logic [9:0] got, input logic [9:0] exp, input logic neq, input string what);
        checks++;
        if (neq ? ((got === exp) || $isunknown(got)) : (got !== exp)) begin
            err_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        @(posedge clk_sys);
        #1 cmp({2'b00, reg_rd_data}, {2'b00, exp}, 1'b0, "register");
    endtask : rd
    task automatic frm(input logic [9:0] smp, input logic [9:0] exp, input logic neq);
        @(posedge clk_sys);
        frame_strobe <= 1'b1;
        sample_in <= smp;
        expq.push_back({neq, exp});
        nfrm++;
        @(posedge clk_sys);
        frame_strobe <= 1'b0;
    endtask : frm
    // Expected word: format flips the top bit where it applies, invert then covers every bit.
    function automatic logic [9:0] fw(input logic [9:0] w, input logic f);
        fw = w ^ {f & fmt[0], 9'h000} ^ {10{inv}};
    endfunction : fw
    always @(posedge clk_sys) begin
        if (got_valid === 1'b1) begin
            if (expq.size() == 0) begin
                checks++;
                err_count++;
                $display("CHECK FAILED t=%0t unexpected word %h", $time, got_word);
            end else begin
                e = expq.pop_front();
                cmp(got_word, e[9:0], e[10], "word");
            end
        end
    end
    initial begin
        #(50 * 5000);
        err_count++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        wrap_up();
    end
    initial begin
        reset_n = 1'b0; reg_wr_en = 1'b0; reg_addr = 8'h00; reg_wr_data = 8'h00;
        frame_strobe = 1'b0; sample_in = 10'h000; fmt = 2'b00; inv = 1'b0;
        ua = 16'($urandom(32'ha171));
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        foreach (rtab[i]) rd(rtab[i][15:8], rtab[i][7:0]);
        foreach (wtab[i]) begin
            wr(wtab[i][23:16], wtab[i][15:8]);
            rd(wtab[i][23:16], wtab[i][7:0]);
        end
        cmp({8'h00, driver_term}, 10'h003, 1'b0, "termination");
        ua = 16'($urandom);
        ub = 16'($urandom);
        wr(8'h19, ua[7:0]); wr(8'h1a, ua[15:8]); wr(8'h1b, ub[7:0]); wr(8'h1c, ub[15:8]);
        rd(8'h1a, ua[15:8]);
        wr(8'h0d, 8'h00);
        for (int k = 0; k < 8; k++) begin
            fmt = {1'b0, k[0]};
            inv = k[1];
            wr(8'h14, {5'h00, inv, fmt});
            s = 10'($urandom);
            frm(s, fw(s, 1'b1), 1'b0);
        end
        for (int j = 0; j < 2; j++) begin
            fmt = {1'b0, j[0]};
            inv = j[0];
            wr(8'h14, {5'h00, inv, fmt});
            foreach (ftab[i]) begin
                wr(8'h0d, {4'h0, ftab[i][14:11]});
                frm(10'($urandom), fw(ftab[i][9:0], ftab[i][10]), 1'b0);
            end
        end
        alt_a = '{10'h2aa, 10'h3ff, ua[15:6]};
        alt_b = '{10'h155, 10'h000, ub[15:6]};
        foreach (alt_m[i]) begin
            wr(8'h0d, {4'h0, alt_m[i]});
            repeat (2) frm(10'h000, fw(nfrm[0] ? alt_b[i] : alt_a[i], 1'b0), 1'b0);
        end
        fmt = 2'b00;
        inv = 1'b0;
        wr(8'h14, 8'h00);
        wr(8'h0d, 8'h36);
        repeat (2) frm(10'h000, {1'b0, aotf_pkg::SEED_SHORT}, 1'b0);
        wr(8'h0d, 8'h20);
        s = 10'($urandom);
        frm(s, s, 1'b0);
        wr(8'h0d, 8'h26);
        frm(10'h000, {1'b0, aotf_pkg::SEED_SHORT}, 1'b1);
        wr(8'h0d, 8'h25);
        frm(10'h000, aotf_pkg::SEED_LONG[9:0], 1'b0);
        wr(8'h0d, 8'h00);
        prev = 4'ha;
        for (int c = 0; c <= 10; c++) begin
            wr(8'h16, 8'(c));
            cmp({6'h00, out_clk_phase}, {6'h00, prev}, 1'b0, "phase early");
            s = 10'($urandom);
            frm(s, s, 1'b0);
            #1 cmp({6'h00, out_clk_phase}, 10'(c), 1'b0, "phase");
            prev = 4'(c);
        end
        repeat (6) @(posedge clk_sys);
        cmp(10'(expq.size()), 10'h000, 1'b0, "words missing");
        wrap_up();
    end
endmodule : test_adc_output_test_format_ctrl
`default_nettype wire
